// ### hw/pcs_map.vh
// Constants for the program counter sequencer
`ifndef PCS_MAP_VH
`define PCS_MAP_VH
`define PCS_PC_W        12
`define PCS_PHASE_LAST  2'h3
`define PCS_WAIT_LONG   11'h0400
`define PCS_WAIT_SHORT  11'h0002
`define PCS_DADDR_PCL   8'h06
`define PCS_VEC_RESET   12'h000
`define PCS_VEC_EXT     12'h004
`define PCS_VEC_TMR0    12'h008
`define PCS_VEC_TMR1    12'h00C
`define PCS_VEC_TMR2    12'h010
`define PCS_VEC_ADC     12'h014
`define PCS_VEC_TOUCH   12'h018
`define PCS_STACK_DEPTH 4
// AXI register byte addresses
`define PCS_A_PCL       12'h018 // Four times data address 06H
`define PCS_A_CTRL      12'h010
`define PCS_A_STATUS    12'h014
`define PCS_A_SP        12'h01C
// Control register bits
`define PCS_CTRL_XTAL   0
`define PCS_CTRL_SHORT  1
`define PCS_CTRL_HALT   2
// AXI responses
`define PCS_RESP_OKAY   2'h0
`define PCS_RESP_SLVERR 2'h2
`endif

// ### hw/pcs_stack.v
// Four-level return address stack that drops the oldest entry on overflow
`timescale 1ns/1ps
module pcs_stack #(
  parameter DEPTH = 4,
  parameter W     = 12
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // Control
  input  wire         push,
  input  wire         pop,
  input  wire [W-1:0] push_data,
  // State
  output wire [W-1:0] top,
  output reg  [2:0]   count_reg
);
  reg [W-1:0] mem [0:DEPTH-1];
  integer i;

  // Shift register stack: entry 0 is the top
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 3'h0;
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {W{1'b0}};
      end
    end else if (push) begin
      for (i = DEPTH - 1; i > 0; i = i - 1) begin
        mem[i] <= mem[i-1];
      end
      mem[0] <= push_data;
      if (count_reg != DEPTH) begin
        count_reg <= count_reg + 3'h1;
      end
    end else if (pop) begin
      for (i = 0; i < DEPTH - 1; i = i + 1) begin
        mem[i] <= mem[i+1];
      end
      if (count_reg != 3'h0) begin
        count_reg <= count_reg - 3'h1;
      end
    end
  end

  assign top = mem[0];
endmodule

// ### hw/pcs_top.v
// Program counter sequencer with four-phase timing, stack, vectors and AXI4-Lite registers
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pcs_map.vh"
module pcs_top (
  // Clock and reset
  input  wire        REF_CLK,
  input  wire        RSTN,
  // Instruction flow from decode
  input  wire [14:0] INSTR_WORD,
  input  wire        OP_JUMP,
  input  wire        OP_CALL,
  input  wire        OP_RET,
  input  wire        OP_SKIP_TRUE,
  input  wire        PCL_WR,
  input  wire [7:0]  PCL_WDATA,
  // Interrupt acknowledge, one bit per source
  input  wire [5:0]  INT_ACK,
  // Wake from halt, pin level
  input  wire        WAKE,
  // Program memory, decode timing and run status
  output reg  [11:0] PROG_ADDR,
  output reg         FETCH_STB,
  output reg         EXEC_STB,
  output reg         EXEC_DUMMY,
  output reg  [1:0]  PHASE,
  output reg  [7:0]  PCL_RDATA,
  output reg         RUNNING,
  // AXI4-Lite write address
  input  wire [11:0] S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  // AXI4-Lite write response
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire [11:0] S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  // AXI4-Lite read data
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY
);
  localparam W = `PCS_PC_W;

  // Vector for the highest priority acknowledged source
  function [11:0] vec_of;
    input [5:0] ack;
    begin
      if (ack[0])      vec_of = `PCS_VEC_EXT;
      else if (ack[1]) vec_of = `PCS_VEC_TMR0;
      else if (ack[2]) vec_of = `PCS_VEC_TMR1;
      else if (ack[3]) vec_of = `PCS_VEC_TMR2;
      else if (ack[4]) vec_of = `PCS_VEC_ADC;
      else             vec_of = `PCS_VEC_TOUCH;
    end
  endfunction

  // Byte lane merge for register writes
  function [7:0] lane0;
    input [7:0] old;
    input [31:0] d;
    input [3:0] s;
    begin
      lane0 = s[0] ? d[7:0] : old;
    end
  endfunction

  reg  [1:0]   phase_reg;
  reg  [W-1:0] pc_reg;
  reg          refill_reg;
  reg          halt_reg;
  reg  [10:0]  wait_reg;
  reg  [2:0]   ctrl_reg;
  reg          wake_s1, wake_s2, wake_s3;
  reg          pc_loaded;
  reg  [W-1:0] pc_next;
  reg          push;
  reg          pop;
  reg          pcl_take;
  reg          pcl_pend_reg;
  reg  [7:0]   pcl_byte_reg;
  wire [W-1:0] stack_top;
  wire [2:0]   stack_count;
  wire         cyc_end = (phase_reg == `PCS_PHASE_LAST);
  wire         waiting = (wait_reg != 11'h000);
  wire         run     = !halt_reg && !waiting;
  wire         wake_ev = wake_s2 && wake_s3;
  wire [10:0]  wait_len = (!ctrl_reg[`PCS_CTRL_XTAL] && ctrl_reg[`PCS_CTRL_SHORT]) ?
                          `PCS_WAIT_SHORT : `PCS_WAIT_LONG;

  // AXI state
  reg          aw_have, w_have;
  reg  [11:0]  aw_addr;
  reg  [31:0]  w_data;
  reg  [3:0]   w_strb;
  wire         do_write = aw_have && w_have && !S_AXI_BVALID;
  wire         axi_pcl_wr = do_write && (aw_addr == `PCS_A_PCL) && w_strb[0];
  wire         any_pcl_wr = PCL_WR || pcl_pend_reg;
  wire [7:0]   pcl_val = PCL_WR ? PCL_WDATA : pcl_byte_reg;
  // Halt takes effect only at an instruction boundary
  wire         halt_req = run && cyc_end && ctrl_reg[`PCS_CTRL_HALT];

  pcs_stack #(
    .DEPTH (`PCS_STACK_DEPTH),
    .W     (W)
  ) u_stack (
    .clk       (REF_CLK),
    .rst_n     (RSTN),
    .push      (push),
    .pop       (pop),
    .push_data (pc_reg),
    .top       (stack_top),
    .count_reg (stack_count)
  );

  // Wake pin synchroniser, three stages
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_s3 <= 1'b0;
    end else begin
      wake_s1 <= WAKE;
      wake_s2 <= wake_s1;
      wake_s3 <= wake_s2;
    end
  end

  // Next counter value, decided once per instruction cycle
  always @* begin
    pc_next   = pc_reg + 12'h001;
    pc_loaded = 1'b0;
    push      = 1'b0;
    pop       = 1'b0;
    pcl_take  = 1'b0;
    if (run && cyc_end) begin
      if (refill_reg) begin
        pc_next = pc_reg + 12'h001;
      end else if (INT_ACK != 6'h00) begin
        pc_next   = vec_of(INT_ACK);
        pc_loaded = 1'b1;
        push      = 1'b1;
      end else if (OP_CALL) begin
        pc_next   = INSTR_WORD[11:0];
        pc_loaded = 1'b1;
        push      = 1'b1;
      end else if (OP_JUMP) begin
        pc_next   = INSTR_WORD[11:0];
        pc_loaded = 1'b1;
      end else if (OP_RET) begin
        pc_next   = stack_top;
        pc_loaded = 1'b1;
        pop       = 1'b1;
      end else if (any_pcl_wr) begin
        pc_next   = {pc_reg[11:8], pcl_val};
        pc_loaded = 1'b1;
        pcl_take  = 1'b1;
      end else if (OP_SKIP_TRUE) begin
        pc_next   = pc_reg + 12'h001;
        pc_loaded = 1'b1;
      end
    end
  end

  // Phase counter, counter, refill and halt control
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      phase_reg  <= 2'h0;
      pc_reg     <= `PCS_VEC_RESET;
      refill_reg <= 1'b0;
      halt_reg   <= 1'b0;
      wait_reg   <= 11'h000;
    end else begin
      if (run) begin
        phase_reg <= phase_reg + 2'h1;
      end
      if (run && cyc_end) begin
        pc_reg     <= pc_next;
        refill_reg <= pc_loaded && !refill_reg;
      end
      if (halt_req) begin
        halt_reg <= 1'b1;
      end else if (halt_reg && wake_ev) begin
        halt_reg <= 1'b0;
        wait_reg <= wait_len;
      end else if (waiting) begin
        wait_reg <= wait_reg - 11'h001;
      end
    end
  end

  // Bus write of the low byte held until a boundary takes it
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pcl_pend_reg <= 1'b0;
      pcl_byte_reg <= 8'h00;
    end else if (axi_pcl_wr) begin
      pcl_pend_reg <= 1'b1;
      pcl_byte_reg <= lane0(pc_reg[7:0], w_data, w_strb);
    end else if (pcl_take) begin
      pcl_pend_reg <= 1'b0;
    end
  end

  // Registered outputs towards memory and decode
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PROG_ADDR  <= 12'h000;
      FETCH_STB  <= 1'b0;
      EXEC_STB   <= 1'b0;
      EXEC_DUMMY <= 1'b0;
      PHASE      <= 2'h0;
      PCL_RDATA  <= 8'h00;
      RUNNING    <= 1'b0;
    end else begin
      PROG_ADDR  <= pc_reg;
      FETCH_STB  <= run && (phase_reg == 2'h0);
      EXEC_STB   <= run && cyc_end && !refill_reg;
      EXEC_DUMMY <= run && cyc_end && refill_reg;
      PHASE      <= phase_reg;
      PCL_RDATA  <= pc_reg[7:0];
      RUNNING    <= run;
    end
  end

  // AXI write channel: take address and data in either order
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `PCS_RESP_OKAY;
      ctrl_reg      <= 3'h0;
    end else begin
      S_AXI_AWREADY <= !aw_have && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY  <= !w_have && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (halt_reg) begin
        ctrl_reg[`PCS_CTRL_HALT] <= 1'b0; // Consumed; a bus write below wins
      end
      if (do_write) begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= `PCS_RESP_OKAY;
        if (aw_addr == `PCS_A_CTRL) begin
          if (w_strb[0]) ctrl_reg <= w_data[2:0];
        end else if (aw_addr != `PCS_A_PCL) begin
          S_AXI_BRESP <= `PCS_RESP_SLVERR;
        end
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // AXI read channel, one cycle after address
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `PCS_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= `PCS_RESP_OKAY;
        case (S_AXI_ARADDR)
          `PCS_A_PCL:    S_AXI_RDATA <= {24'h00_0000, pc_reg[7:0]};
          `PCS_A_CTRL:   S_AXI_RDATA <= {29'h0000_0000, ctrl_reg};
          `PCS_A_STATUS: S_AXI_RDATA <= {16'h0000, 4'h0, pc_reg};
          `PCS_A_SP:     S_AXI_RDATA <= {19'h0_0000, waiting, halt_reg, 8'h00, stack_count};
          default: begin
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `PCS_RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule

// ### sim/pcs_properties.sv
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
module pcs_properties (
  // Clock and reset
  input wire        REF_CLK,
  input wire        RSTN,
  // Sequencing outputs
  input wire [11:0] PROG_ADDR,
  input wire        FETCH_STB,
  input wire        EXEC_STB,
  input wire        EXEC_DUMMY,
  input wire [1:0]  PHASE,
  input wire        RUNNING,
  // Register bus
  input wire        S_AXI_ARREADY,
  input wire [1:0]  S_AXI_BRESP,
  input wire        S_AXI_BVALID,
  input wire        S_AXI_BREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire [1:0]  S_AXI_RRESP,
  input wire        S_AXI_RVALID,
  input wire        S_AXI_RREADY
);
  // One clock and one reset for every check
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  // Instruction cycle timing
  phase_step_a: assert property (
    RUNNING && $past(RUNNING) |-> PHASE == $past(PHASE) + 2'h1) else $error("phase skipped");
  fetch_once_a: assert property (
    FETCH_STB |=> !FETCH_STB [*3]) else $error("fetch too soon");
  exec_follow_a: assert property (
    FETCH_STB |-> ##[0:4] (EXEC_STB || EXEC_DUMMY)) else $error("no execute");
  exec_excl_a: assert property (
    !(EXEC_STB && EXEC_DUMMY)) else $error("execute and refill together");
  refill_fetch_a: assert property (
    EXEC_DUMMY |-> ##[1:4] FETCH_STB) else $error("no fetch after refill");
  // Counter frozen while stopped
  wait_hold_a: assert property (
    !RUNNING && !$past(RUNNING) |-> $stable(PROG_ADDR) && !FETCH_STB) else $error("moved in wait");
  // Register bus answers
  ar_answer_a: assert property (
    S_AXI_ARREADY |=> S_AXI_RVALID) else $error("late read data");
  bresp_hold_a: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  rdata_hold_a: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  // Main scenarios reached
  cover property (EXEC_DUMMY);
  cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
  cover property (!RUNNING ##1 RUNNING);
endmodule

// ### sim/pcs_progmem.sv
// Program memory model answering each fetch
`timescale 1ns/1ps
module pcs_progmem (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Fetch request
  input  wire [11:0] addr,
  input  wire        stb,
  // Fetched word
  output reg  [14:0] word
);
  reg [14:0] fetched;
  // High page words target the low page and back; a word executes one fetch later
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetched <= 15'h0000;
      word <= 15'h0000;
    end else if (stb) begin
      fetched <= {3'h0, addr[11] ? 12'h123 : 12'hA50};
      word <= fetched;
    end
  end
endmodule

// ### sim/pcs_bench.sv
// Self-checking bench for the sequencer
`timescale 1ns/1ps
`include "pcs_map.vh"
`define CHK(x, e) begin num_checks = num_checks + 1; if ((x) !== (e)) begin \
  n_errors = n_errors + 1; $display("MISMATCH t=%0t got=%h exp=%h", $time, (x), (e)); end end
module pcs_bench;
  reg         clk = 1'b0, rstn = 1'b0, wake = 1'b0, f;
  reg  [4:0]  ops = 5'h00;
  reg  [7:0]  wd = 8'h00;
  reg  [5:0]  ack = 6'h00;
  reg  [11:0] awaddr = 12'h000, araddr = 12'h000, a, b;
  reg  [31:0] wdata = 32'h0000_0000, r;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire [14:0] word;
  wire [11:0] pa;
  wire        fstb, dummy, run, awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [7:0]  pcl_q;
  reg  [7:0]  c;
  integer     n_errors = 0, num_checks = 0, cyc = 0, n_dummy = 0, gap = 0, i;
  // Clock
  always #2 clk = ~clk;
  pcs_progmem mem (.clk(clk), .rst_n(rstn), .addr(pa), .stb(fstb), .word(word));
  pcs_top uut (.REF_CLK(clk), .RSTN(rstn), .INSTR_WORD(word), .OP_JUMP(ops[4]),
    .OP_CALL(ops[3]), .OP_RET(ops[2]), .OP_SKIP_TRUE(ops[1]), .PCL_WR(ops[0]),
    .PCL_WDATA(wd), .INT_ACK(ack), .WAKE(wake), .PROG_ADDR(pa), .FETCH_STB(fstb),
    .EXEC_STB(), .EXEC_DUMMY(dummy), .PHASE(), .PCL_RDATA(pcl_q), .RUNNING(run),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  // Verdict and end of run
  task print_verdict;
    begin
      if (n_errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  // Hang limit
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      print_verdict;
    end
  end
  // Wait for the next fetch, counting refills seen
  task fetch;
    integer k;
    begin
      a = 12'hFFF;
      for (k = 1; k < 40 && a === 12'hFFF; k = k + 1) begin
        @(posedge clk);
        if (dummy === 1'b1) n_dummy = n_dummy + 1;
        if (fstb === 1'b1) begin
          a = pa;
          gap = k;
        end
      end
    end
  endtask
  // Hold a decode request from one fetch to the next, then seek target and one refill
  task op(input [4:0] s, input [5:0] q, input [7:0] w, input [11:0] t);
    integer d;
    begin
      fetch;
      d = n_dummy;
      ops <= s;
      ack <= q;
      wd <= w;
      fetch;
      ops <= 5'h00;
      ack <= 6'h00;
      f = (a === t);
      repeat (2) begin
        fetch;
        if (a === t) f = 1'b1;
      end
      if (t !== 12'hFFF) `CHK(f, 1'b1)
      `CHK(n_dummy - d, 1)
    end
  endtask
  // Register write, response taken at the edge it is seen
  task wr(input [11:0] ad, input [31:0] d, input [1:0] e);
    integer   k;
    reg       got;
    reg [1:0] rsp;
    begin
      @(posedge clk);
      got = 1'b0;
      rsp = 2'h3;
      awaddr <= ad;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 50 && !got; k = k + 1) begin
        @(posedge clk);
        if (awready === 1'b1) awvalid <= 1'b0;
        if (wready === 1'b1) wvalid <= 1'b0;
        if (bvalid === 1'b1) begin
          got = 1'b1;
          rsp = bresp;
          bready <= 1'b0;
        end
      end
      `CHK(got, 1'b1)
      `CHK(rsp, e)
    end
  endtask
  // Register read, data taken at the edge it is seen
  task rd(input [11:0] ad, input [1:0] e);
    integer   k;
    reg       got;
    reg [1:0] rsp;
    begin
      @(posedge clk);
      got = 1'b0;
      rsp = 2'h3;
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 50 && !got; k = k + 1) begin
        @(posedge clk);
        if (arready === 1'b1) arvalid <= 1'b0;
        if (rvalid === 1'b1) begin
          got = 1'b1;
          rsp = rresp;
          r = rdata;
          rready <= 1'b0;
        end
      end
      `CHK(got, 1'b1)
      `CHK(rsp, e)
    end
  endtask
  // Bus write of the low byte: short jump in the same page, then read back
  task pcl_bus;
    integer k;
    begin
      b = pa;
      wr(`PCS_A_PCL, 32'h0000_0077, `PCS_RESP_OKAY);
      f = 1'b0;
      c = 8'h00;
      for (k = 0; k < 3 && !f; k = k + 1) begin
        fetch;
        if (a === {b[11:8], 8'h77}) begin
          f = 1'b1;
          c = pcl_q;
        end
      end
      `CHK(f, 1'b1)
      `CHK(c, 8'h77)
      rd(`PCS_A_PCL, `PCS_RESP_OKAY);
      `CHK(r >= 32'h0000_0077 && r <= 32'h0000_007A, 1'b1)
    end
  endtask
  // Halt, wake, and time the start-up wait
  task wake_test(input [2:0] cfg, input integer w);
    integer n;
    begin
      wr(`PCS_A_CTRL, {29'h0, cfg} | 32'h0000_0004, `PCS_RESP_OKAY);
      for (n = 0; n < 40 && run !== 1'b0; n = n + 1) @(posedge clk);
      b = pa;
      wake <= 1'b1;
      f = 1'b1;
      for (n = 0; n < 1100 && run !== 1'b1; n = n + 1) begin
        @(posedge clk);
        if (run !== 1'b1 && (fstb !== 1'b0 || pa !== b)) f = 1'b0;
      end
      wake <= 1'b0;
      `CHK(f, 1'b1)
      `CHK(n >= w && n <= w + 8, 1'b1)
    end
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    fetch;
    `CHK(a, `PCS_VEC_RESET)
    b = a;
    fetch;
    `CHK(a, b + 12'h001)
    `CHK(gap, 4)
    op(5'h10, 6'h00, 8'h00, 12'hA50);
    op(5'h01, 6'h00, 8'h3C, 12'hA3C);
    op(5'h02, 6'h00, 8'h00, 12'hA40);
    for (i = 0; i < 5; i = i + 1) op(5'h08, 6'h00, 8'h00, i[0] ? 12'hA50 : 12'h123);
    rd(`PCS_A_SP, `PCS_RESP_OKAY);
    `CHK(r[2:0], 3'h4)
    op(5'h04, 6'h00, 8'h00, 12'hA53);
    `CHK(a[11:8], 4'hA)
    rd(`PCS_A_SP, `PCS_RESP_OKAY);
    `CHK(r[2:0], 3'h3)
    for (i = 0; i < 6; i = i + 1) op(5'h00, 6'h01 << i, 8'h00, 12'h004 * (i + 1));
    op(5'h00, 6'h3F, 8'h00, `PCS_VEC_EXT);
    pcl_bus;
    rd(12'h0FC, `PCS_RESP_SLVERR);
    `CHK(r, 32'h0000_0000)
    wr(12'h0FC, 32'h0000_0055, `PCS_RESP_SLVERR);
    wake_test(3'h1, `PCS_WAIT_LONG);
    wake_test(3'h2, `PCS_WAIT_SHORT);
    wake_test(3'h0, `PCS_WAIT_LONG);
    print_verdict;
  end
endmodule
bind pcs_top pcs_properties u_prop (.REF_CLK(REF_CLK), .RSTN(RSTN), .PROG_ADDR(PROG_ADDR),
  .FETCH_STB(FETCH_STB), .EXEC_STB(EXEC_STB), .EXEC_DUMMY(EXEC_DUMMY), .PHASE(PHASE),
  .RUNNING(RUNNING), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));
